// >>> rtl/remap_map.svh
// constants of the dma address remapping engine: widths, entry layouts, counts
// assumes inclusion by bare name from the package only
`ifndef REMAP_MAP_SVH
`define REMAP_MAP_SVH
`define ADDR_W         46
`define AGAW           48
`define TOP_LEVEL      3'd4
`define PG_SHIFT       12
`define LVL_BITS       9
`define DOM_W          16
`define CACHE_N        8
`define CACHE_IDX_W    3
`define ENT_RD         0
`define ENT_WR         1
`define ENT_SUPER      7
`define ENT_PRESENT    0
`define CTX_DOM_LSB    48
`define ROOT_ENT_SHIFT 4
`define CTX_ENT_SHIFT  4
`define PTE_SHIFT      3
`define IRT_ENT_SHIFT  4
`define IRT_VEC_LSB    16
`define IRT_DEST_LSB   32
`define HANDLE_LSB     5
`define HANDLE_W       15
`define PEND_W         8
`define GFX_BDF_RST    16'h0010
`endif

// >>> rtl/remap_pkg.sv
// types shared by the remapping engine and its translation cache
// assumes remap_map.svh is on the include path
package remap_pkg;
  `include "remap_map.svh"

  typedef struct packed {
    logic [15:0]         bdf;
    logic [`ADDR_W-1:0]  addr;
    logic                write;
    logic                intr;
    logic                pasid_vld;
    logic                nested;
  } req_t;

  typedef struct packed {
    logic [`ADDR_W-1:0]  hpa;
    logic                write;
    logic                intr;
    logic [7:0]          vector;
    logic [31:0]         dest;
    logic [`DOM_W-1:0]   domain;
  } out_t;

  typedef enum logic [2:0] {F_NONE, F_ROOT, F_CTX, F_PTE, F_PERM, F_UNIT, F_IRT, F_MODE}
    fault_code_t;

  typedef struct packed {
    logic                valid;
    fault_code_t         code;
    logic [15:0]         bdf;
    logic [`ADDR_W-1:0]  addr;
  } fault_t;

  typedef enum logic [1:0] {INV_ALL, INV_DOMAIN, INV_PAGE} inv_scope_t;

  typedef struct packed {
    inv_scope_t          scope;
    logic [`DOM_W-1:0]   domain;
    logic [33:0]         page;
  } inv_t;

  typedef struct packed {
    logic [`ADDR_W-1:0]  root_ptr;
    logic [`ADDR_W-1:0]  irt_base;
    logic                xlate_en;
    logic                intr_remap_en;
    logic                scalable_en;
  } cfg_t;
endpackage

// >>> rtl/io_translation_cache.sv
// io_translation_cache: fully associative cache of leaf and non-leaf table entries
// assumes insert and invalidate never occur in the same cycle
`timescale 1ns/1ps
module io_translation_cache (
  input  wire logic               i_clk,
  input  wire logic               i_srst,
  input  wire logic [`DOM_W-1:0]  i_domain,
  input  wire logic [2:0]         i_level,
  input  wire logic [33:0]        i_gpn,
  output logic                    o_hit,
  output logic [63:0]             o_data,
  input  wire logic               i_ins,
  input  wire logic [63:0]        i_ins_data,
  input  wire logic               i_inv,
  input  wire remap_pkg::inv_t    i_inv_cmd
);
  import remap_pkg::*;

  logic [`CACHE_N-1:0]     match;
  logic [63:0]             dsel [`CACHE_N];
  logic [`CACHE_IDX_W-1:0] vict_q;

  // an entry at level l depends on its own index bits and every page-number bit above them
  function automatic logic [33:0] lvl_mask(input logic [2:0] l);
    lvl_mask = ~34'h0 << (`LVL_BITS * (int'(l) - 1));
  endfunction

  for (genvar g = 0; g < `CACHE_N; g++) begin : g_ent
    logic              vld_q;
    logic [`DOM_W-1:0] dom_q;
    logic [2:0]        lvl_q;
    logic [33:0]       gpn_q;
    logic [63:0]       dat_q;
    logic              kill;
    assign match[g] = vld_q && dom_q == i_domain && lvl_q == i_level &&
                      ((gpn_q ^ i_gpn) & lvl_mask(lvl_q)) == 34'h0;
    assign dsel[g]  = match[g] ? dat_q : 64'h0;
    assign kill = i_inv && vld_q && (i_inv_cmd.scope == INV_ALL ||
                  (dom_q == i_inv_cmd.domain && (i_inv_cmd.scope == INV_DOMAIN ||
                  ((gpn_q ^ i_inv_cmd.page) & lvl_mask(lvl_q)) == 34'h0)));
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        vld_q <= 1'b0;
      end else if (i_ins && vict_q == `CACHE_IDX_W'(g)) begin
        vld_q <= 1'b1;
      end else if (kill) begin
        vld_q <= 1'b0;
      end
    end
    always_ff @(posedge i_clk) begin
      if (i_ins && vict_q == `CACHE_IDX_W'(g)) begin
        dom_q <= i_domain;
        lvl_q <= i_level;
        gpn_q <= i_gpn;
        dat_q <= i_ins_data;
      end
    end
  end

  always_comb begin
    o_data = 64'h0;
    for (int i = 0; i < `CACHE_N; i++) begin
      o_data = o_data | dsel[i];
    end
  end
  assign o_hit = |match;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      vict_q <= '0;
    end else if (i_ins) begin
      vict_q <= vict_q + `CACHE_IDX_W'(1);
    end
  end
endmodule // io_translation_cache

// >>> rtl/dma_address_remapping_engine.sv
// dma_address_remapping_engine: per-requester table walk, fault record, invalidation
// assumes table memory answers each read once; configuration is stable while busy
`timescale 1ns/1ps
module dma_address_remapping_engine #(
  parameter logic        IS_GRAPHICS = 1'b0,
  parameter logic [15:0] GFX_BDF     = `GFX_BDF_RST
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  input  wire remap_pkg::cfg_t       i_cfg,
  input  wire logic                  i_req_valid,
  output logic                       o_req_ready,
  input  wire remap_pkg::req_t       i_req,
  output logic                       o_out_valid,
  input  wire logic                  i_out_ready,
  output remap_pkg::out_t            o_out,
  input  wire logic                  i_fwd_done,
  output logic                       o_mem_valid,
  output logic [`ADDR_W-1:0]         o_mem_addr,
  input  wire logic                  i_mem_rvalid,
  input  wire logic [63:0]           i_mem_rdata,
  output remap_pkg::fault_t          o_fault,
  output logic                       o_msi,
  input  wire logic                  i_fault_clear,
  input  wire logic                  i_reg_inv_valid,
  output logic                       o_reg_inv_ready,
  input  wire remap_pkg::inv_t       i_reg_inv,
  input  wire logic                  i_q_inv_valid,
  output logic                       o_q_inv_ready,
  input  wire remap_pkg::inv_t       i_q_inv,
  output logic                       o_inv_done
);
  import remap_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_ROOT, S_CTX, S_WALK, S_IRT, S_SEND, S_FAULT, S_DRAIN}
    state_t;

  state_t             state_q;
  req_t               req_q;
  out_t               out_q;
  fault_code_t        code_q;
  fault_code_t        pre_code;
  fault_t             fault_q;
  inv_t               inv_q;
  logic [`ADDR_W-1:0] tbl_q;
  logic [2:0]         level_q;
  logic [`DOM_W-1:0]  dom_q;
  logic               mem_req_q;
  logic [`ADDR_W-1:0] mem_addr_q;
  logic [`PEND_W-1:0] pend_q;
  logic               msi_q;
  logic               done_q;
  logic               take_req;
  logic               take_inv;
  logic               fetch_st;
  logic               c_hit;
  logic [63:0]        c_data;
  logic               walk_hit;
  logic               ent_ok;
  logic [63:0]        ent;
  logic               ent_live;
  logic               perm_ok;
  logic               walk_leaf;
  logic               cache_ins;
  logic               cache_inv;
  logic [8:0]         idx;
  logic [`ADDR_W-1:0] fetch_addr;
  logic [`ADDR_W-1:0] leaf_hpa;
  logic               rec;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  ////////////////////////////////////////////////////////////////////////////
  // request and invalidation intake; invalidations win over new requests

  assign take_inv        = (i_reg_inv_valid || i_q_inv_valid) && state_q == S_IDLE;
  assign o_reg_inv_ready = state_q == S_IDLE;
  assign o_q_inv_ready   = state_q == S_IDLE && !i_reg_inv_valid;
  assign o_req_ready     = state_q == S_IDLE && !i_reg_inv_valid && !i_q_inv_valid;
  assign take_req        = i_req_valid && o_req_ready;

  always_comb begin
    if ((i_req.bdf == GFX_BDF) != IS_GRAPHICS) begin
      pre_code = F_UNIT;
    end else if (i_req.nested && IS_GRAPHICS) begin
      pre_code = F_MODE;
    end else if (i_req.pasid_vld && !i_cfg.scalable_en) begin
      pre_code = F_MODE;
    end else begin
      pre_code = F_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // table fetch: address per walk stage, cache or memory supplies the entry

  assign fetch_st = state_q == S_ROOT || state_q == S_CTX ||
                    state_q == S_WALK || state_q == S_IRT;
  assign idx = 9'(req_q.addr >> (`PG_SHIFT + `LVL_BITS * (int'(level_q) - 1)));

  always_comb begin
    unique case (state_q)
      S_ROOT:  fetch_addr = i_cfg.root_ptr + (`ADDR_W'(req_q.bdf[15:8]) << `ROOT_ENT_SHIFT);
      S_CTX:   fetch_addr = tbl_q + (`ADDR_W'(req_q.bdf[7:0]) << `CTX_ENT_SHIFT);
      S_WALK:  fetch_addr = tbl_q + (`ADDR_W'(idx) << `PTE_SHIFT);
      S_IRT:   fetch_addr = i_cfg.irt_base +
                            (`ADDR_W'(req_q.addr[`HANDLE_LSB +: `HANDLE_W]) << `IRT_ENT_SHIFT);
      default: fetch_addr = tbl_q;
    endcase
  end

  assign walk_hit  = state_q == S_WALK && c_hit && !mem_req_q;
  assign ent_ok    = walk_hit || (mem_req_q && i_mem_rvalid);
  assign ent       = walk_hit ? c_data : i_mem_rdata;
  assign ent_live  = ent[`ENT_RD] || ent[`ENT_WR];
  assign perm_ok   = req_q.write ? ent[`ENT_WR] : ent[`ENT_RD];
  assign walk_leaf = level_q == 3'd1 ||
                     (ent[`ENT_SUPER] && (level_q == 3'd2 || level_q == 3'd3));
  assign cache_ins = state_q == S_WALK && mem_req_q && i_mem_rvalid && ent_live;
  assign cache_inv = state_q == S_DRAIN && pend_q == '0;

  always_comb begin
    unique case (level_q)
      3'd3:    leaf_hpa = {ent[45:30], req_q.addr[29:0]};
      3'd2:    leaf_hpa = {ent[45:21], req_q.addr[20:0]};
      default: leaf_hpa = {ent[45:12], req_q.addr[11:0]};
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mem_req_q  <= 1'b0;
      mem_addr_q <= '0;
    end else if (mem_req_q && i_mem_rvalid) begin
      mem_req_q  <= 1'b0;
    end else if (fetch_st && !mem_req_q && !walk_hit) begin
      mem_req_q  <= 1'b1;
      mem_addr_q <= fetch_addr;
    end
  end
  assign o_mem_valid = mem_req_q;
  assign o_mem_addr  = mem_addr_q;

  io_translation_cache u_cache (
    .i_clk      (i_clk),
    .i_srst     (i_srst),
    .i_domain   (dom_q),
    .i_level    (level_q),
    .i_gpn      (req_q.addr[45:12]),
    .o_hit      (c_hit),
    .o_data     (c_data),
    .i_ins      (cache_ins),
    .i_ins_data (i_mem_rdata),
    .i_inv      (cache_inv),
    .i_inv_cmd  (inv_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // walk sequencer

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= S_IDLE;
      req_q   <= '0;
      out_q   <= '0;
      code_q  <= F_NONE;
      tbl_q   <= '0;
      level_q <= `TOP_LEVEL;
      dom_q   <= '0;
      inv_q   <= '0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (take_inv) begin
            inv_q   <= i_reg_inv_valid ? i_reg_inv : i_q_inv;
            state_q <= S_DRAIN;
          end else if (take_req) begin
            req_q   <= i_req;
            out_q   <= '{hpa: i_req.addr, write: i_req.write, intr: i_req.intr,
                         vector: 8'h00, dest: 32'h0, domain: '0};
            code_q  <= pre_code;
            if (pre_code != F_NONE) begin
              state_q <= S_FAULT;
            end else if (i_req.intr) begin
              state_q <= i_cfg.intr_remap_en ? S_IRT : S_SEND;
            end else begin
              state_q <= i_cfg.xlate_en ? S_ROOT : S_SEND;
            end
          end
        end
        S_ROOT: if (ent_ok) begin
          if (!ent[`ENT_PRESENT]) begin
            code_q  <= F_ROOT;
            state_q <= S_FAULT;
          end else begin
            tbl_q   <= {ent[45:12], 12'h000};
            state_q <= S_CTX;
          end
        end
        S_CTX: if (ent_ok) begin
          if (!ent[`ENT_PRESENT]) begin
            code_q  <= F_CTX;
            state_q <= S_FAULT;
          end else begin
            tbl_q   <= {ent[45:12], 12'h000};
            dom_q   <= ent[`CTX_DOM_LSB +: `DOM_W];
            level_q <= `TOP_LEVEL;
            state_q <= S_WALK;
          end
        end
        S_WALK: if (ent_ok) begin
          if (!ent_live || (level_q == `TOP_LEVEL && ent[`ENT_SUPER])) begin
            code_q  <= F_PTE;
            state_q <= S_FAULT;
          end else if (!perm_ok) begin
            code_q  <= F_PERM;
            state_q <= S_FAULT;
          end else if (walk_leaf) begin
            out_q.hpa    <= leaf_hpa;
            out_q.domain <= dom_q;
            state_q      <= S_SEND;
          end else begin
            tbl_q   <= {ent[45:12], 12'h000};
            level_q <= level_q - 3'd1;
          end
        end
        S_IRT: if (ent_ok) begin
          if (!ent[`ENT_PRESENT]) begin
            code_q  <= F_IRT;
            state_q <= S_FAULT;
          end else begin
            out_q.vector <= ent[`IRT_VEC_LSB +: 8];
            out_q.dest   <= ent[`IRT_DEST_LSB +: 32];
            state_q      <= S_SEND;
          end
        end
        S_SEND: if (i_out_ready) begin
          state_q <= S_IDLE;
        end
        S_FAULT: state_q <= S_IDLE;
        S_DRAIN: if (pend_q == '0) begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  assign o_out_valid = state_q == S_SEND;
  assign o_out       = out_q;

  ////////////////////////////////////////////////////////////////////////////
  // forwarded but not yet completed accesses

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_q + `PEND_W'(o_out_valid && i_out_ready)
                       - `PEND_W'(i_fwd_done && pend_q != '0);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= cache_inv;
    end
  end
  assign o_inv_done = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // single fault record; a new fault in the clearing cycle is kept

  assign rec = state_q == S_FAULT && (!fault_q.valid || i_fault_clear);
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fault_q <= '0;
      msi_q   <= 1'b0;
    end else begin
      msi_q <= rec;
      if (rec) begin
        fault_q <= '{valid: 1'b1, code: code_q, bdf: req_q.bdf, addr: req_q.addr};
      end else if (i_fault_clear) begin
        fault_q.valid <= 1'b0;
      end
    end
  end
  assign o_fault = fault_q;
  assign o_msi   = msi_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  root_walk_a: assert property (
    take_req && pre_code == F_NONE && !i_req.intr && i_cfg.xlate_en |=> state_q == S_ROOT)
    else $error("translated request did not start at the root table");
  fwd_send_a: assert property (
    o_out_valid |-> state_q == S_SEND && !mem_req_q)
    else $error("forward while a walk is still open");
  fault_stop_a: assert property (
    state_q == S_FAULT |=> state_q == S_IDLE && !o_out_valid)
    else $error("faulted access was forwarded");
  walk_level_a: assert property (
    state_q == S_WALK |-> level_q inside {[3'd1:3'd4]})
    else $error("walk level outside four levels");
  super_leaf_a: assert property (
    state_q == S_WALK && ent_ok && ent_live && perm_ok && level_q == 3'd3 && ent[`ENT_SUPER]
    |=> state_q == S_SEND && o_out.hpa[29:0] == $past(req_q.addr[29:0]))
    else $error("1 GB page did not end the walk");
  msi_once_a: assert property (
    o_msi |-> fault_q.valid && $past(state_q) == S_FAULT)
    else $error("interrupt without a recorded fault");
  no_bad_cache_a: assert property (
    cache_ins |-> ent_live && !walk_hit)
    else $error("invalid entry inserted into the cache");
  hit_live_a: assert property (
    walk_hit |-> ent_live)
    else $error("cache supplied an entry with no read or write right");
  drain_a: assert property (
    o_inv_done |-> $past(pend_q) == '0 && $past(state_q) == S_DRAIN)
    else $error("invalidation done with accesses pending");
  gfx_nested_a: assert property (
    take_req && IS_GRAPHICS && i_req.nested && pre_code != F_UNIT
    |=> state_q == S_FAULT && code_q == F_MODE)
    else $error("graphics instance accepted nested translation");
  mem_hold_a: assert property (
    o_mem_valid && !i_mem_rvalid |=> o_mem_valid && $stable(o_mem_addr))
    else $error("table read dropped or moved before its answer");
endmodule // dma_address_remapping_engine

// >>> verification/table_memory_model.sv
// table_memory_model: memory with root, context, page and interrupt tables
// assumes one read outstanding at a time; answers 1 to 3 cycles after the request
`timescale 1ns/1ps
module table_memory_model (
  input  wire logic        i_clk,
  input  wire logic        i_mem_valid,
  input  wire logic [45:0] i_mem_addr,
  output logic             o_mem_rvalid,
  output logic [63:0]      o_mem_rdata
);
  logic [63:0] mem [logic [45:0]];
  int          reads = 0;
  int          wt    = 0;
  int          seed  = 32'h0B17;
  bit          ans   = 1'b0;
  bit          v;

  initial begin
    o_mem_rvalid = 1'b0;
    o_mem_rdata  = 64'h0;
  end

  task automatic put(input logic [45:0] a, input logic [63:0] d);
    mem[a] = d;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // data is inverted when idle so a stale read never looks valid
  always @(posedge i_clk) begin
    v = i_mem_valid;
    #1;
    o_mem_rvalid = 1'b0;
    o_mem_rdata  = ~o_mem_rdata;
    if (!v) ans = 1'b0;
    else if (!ans && wt != 0) wt--;
    else if (!ans) begin
      ans          = 1'b1;
      wt           = {$random(seed)} % 3;
      reads++;
      o_mem_rvalid = 1'b1;
      o_mem_rdata  = mem.exists(i_mem_addr) ? mem[i_mem_addr] : 64'h0;
    end
  end
endmodule // table_memory_model

// >>> verification/dma_address_remapping_engine_bench.sv
// dma_address_remapping_engine_bench: walks, faults, invalidations, interrupt remap
// assumes remap_pkg compiled first and table_memory_model as the table memory
`timescale 1ns/1ps
module dma_address_remapping_engine_bench;
  import remap_pkg::*;
  localparam logic [15:0] BDF = 16'h0100;
  localparam logic [45:0] GPA = 46'h0080_8060_4000;
  localparam logic [45:0] SUP = 46'h0080_80A0_0000;
  localparam logic [45:0] BAD = 46'h0080_80C0_0000;
  localparam logic [45:0] GIG = 46'h0080_C000_0000;
  logic        wr = 1'b0, nest = 1'b0;
  logic        i_clk = 1'b0, i_srst = 1'b1, o_req_ready, o_out_valid, o_msi;
  logic        i_req_valid = 1'b0, i_out_ready = 1'b1, i_fwd_done = 1'b0;
  logic        i_fault_clear = 1'b0, i_reg_inv_valid = 1'b0, i_q_inv_valid = 1'b0;
  logic        o_mem_valid, i_mem_rvalid, o_reg_inv_ready, o_q_inv_ready, o_inv_done;
  logic [45:0] o_mem_addr, a;
  logic [63:0] i_mem_rdata;
  logic [31:0] off;
  cfg_t        i_cfg = '{46'h1000, 46'h8000, 1'b1, 1'b0, 1'b0};
  req_t        i_req = '0;
  inv_t        i_reg_inv = '0, i_q_inv = '0;
  out_t        o_out, got;
  fault_t      o_fault, fl, gfx_fault;
  int          seed = 32'h6e26, mismatches = 0, tests_run = 0, k, r0, at;

`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin mismatches++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, s); end end

  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) #1 i_out_ready = $random(seed);

  dma_address_remapping_engine #(.IS_GRAPHICS(1'b0), .GFX_BDF(16'h0010)) i_dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_cfg(i_cfg), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_req(i_req), .o_out_valid(o_out_valid),
    .i_out_ready(i_out_ready), .o_out(o_out), .i_fwd_done(i_fwd_done),
    .o_mem_valid(o_mem_valid), .o_mem_addr(o_mem_addr), .i_mem_rvalid(i_mem_rvalid),
    .i_mem_rdata(i_mem_rdata), .o_fault(o_fault), .o_msi(o_msi),
    .i_fault_clear(i_fault_clear), .i_reg_inv_valid(i_reg_inv_valid),
    .o_reg_inv_ready(o_reg_inv_ready), .i_reg_inv(i_reg_inv),
    .i_q_inv_valid(i_q_inv_valid), .o_q_inv_ready(o_q_inv_ready), .i_q_inv(i_q_inv),
    .o_inv_done(o_inv_done));

  // graphics instance: passthrough only, so it needs no table memory
  dma_address_remapping_engine #(.IS_GRAPHICS(1'b1), .GFX_BDF(16'h0010)) i_gfx (
    .i_clk(i_clk), .i_srst(i_srst), .i_cfg('0), .i_req_valid(i_req_valid),
    .o_req_ready(), .i_req(i_req), .o_out_valid(), .i_out_ready(1'b1), .o_out(),
    .i_fwd_done(i_fwd_done), .o_mem_valid(), .o_mem_addr(), .i_mem_rvalid(1'b0),
    .i_mem_rdata(64'h0), .o_fault(gfx_fault), .o_msi(), .i_fault_clear(i_fault_clear),
    .i_reg_inv_valid(i_reg_inv_valid), .o_reg_inv_ready(), .i_reg_inv(i_reg_inv),
    .i_q_inv_valid(i_q_inv_valid), .o_q_inv_ready(), .i_q_inv(i_q_inv), .o_inv_done());

  table_memory_model i_mem (.i_clk(i_clk), .i_mem_valid(o_mem_valid),
    .i_mem_addr(o_mem_addr), .o_mem_rvalid(i_mem_rvalid), .o_mem_rdata(i_mem_rdata));

  function automatic logic [45:0] expect_hpa(input logic [45:0] g);
    if (g[38:30] == 9'h3) return {16'h8, g[29:0]};
    return (g[29:21] == 9'h5) ? {25'h2, g[20:0]} : {34'h12345, g[11:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // kind: 0 no answer, 1 forwarded, 2 fault signalled
  task automatic req(input logic [15:0] b, input logic [45:0] g, input logic in,
                     input logic pv, input logic done);
    int n;
    i_req       = '{b, g, wr, in, pv, nest};
    i_req_valid = 1'b1;
    do @(posedge i_clk); while (o_req_ready !== 1'b1);
    #1 i_req_valid = 1'b0;
    k = 0;
    for (n = 0; n < 40 && k == 0; n++) begin
      @(posedge i_clk);
      if (o_msi === 1'b1) k = 2;
      else if (o_out_valid === 1'b1 && i_out_ready === 1'b1) k = 1;
      got = o_out;
      fl  = o_fault;
    end
    #1 i_fwd_done = done && k == 1;
    @(posedge i_clk);
    #1 i_fwd_done = 1'b0;
  endtask

  task automatic inv(input bit q, input inv_t c, input int hold);
    int n;
    i_q_inv         = c;
    i_reg_inv       = c;
    i_q_inv_valid   = q;
    i_reg_inv_valid = !q;
    do @(posedge i_clk); while ((q ? o_q_inv_ready : o_reg_inv_ready) !== 1'b1);
    #1 i_q_inv_valid = 1'b0;
    i_reg_inv_valid = 1'b0;
    at = -1;
    for (n = 1; n < 60 && at < 0; n++) begin
      i_fwd_done = (n == hold);
      @(posedge i_clk);
      if (o_inv_done === 1'b1) at = n;
      #1;
    end
    i_fwd_done = 1'b0;
  endtask

  task automatic clr;
    i_fault_clear = 1'b1;
    @(posedge i_clk);
    #1 i_fault_clear = 1'b0;
    @(posedge i_clk);
    #1;
    `CHK("fault cleared", 1'b0, o_fault.valid)
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    stop_test;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_mem.put(46'h1010, 64'h2001);
    i_mem.put(46'h2000, 64'h0005_0000_0000_3001);
    i_mem.put(46'h3008, 64'h4003);
    i_mem.put(46'h4010, 64'h5003);
    i_mem.put(46'h4018, 64'h2_0000_0083);
    i_mem.put(46'h5018, 64'h6003);
    i_mem.put(46'h5028, 64'h0040_0083);
    i_mem.put(46'h6020, 64'h1234_5003);
    i_mem.put(46'h8030, 64'hA5A5_0001_0041_0001);
    repeat (8) @(posedge i_clk);
    #1 i_srst = 1'b0;
    r0 = i_mem.reads;
    req(BDF, GPA | 46'h5A4, 1'b0, 1'b0, 1'b0);
    `CHK("walk kind", 1, k)
    `CHK("walk hpa", expect_hpa(GPA | 46'h5A4), got.hpa)
    `CHK("walk domain", 16'h0005, got.domain)
    `CHK("walk reads", 6, i_mem.reads - r0)
    r0 = i_mem.reads;
    req(BDF, GPA, 1'b0, 1'b0, 1'b1);
    `CHK("warm reads", 2, i_mem.reads - r0)
    inv(1'b0, '{INV_ALL, 16'h5, GPA[45:12]}, 10);
    `CHK("inv drains", 1'b1, at > 10)
    for (int s = 0; s < 3; s++) begin
      req(BDF, GPA, 1'b0, 1'b0, 1'b1);
      inv(s[0], '{inv_scope_t'(s), 16'h5, GPA[45:12]}, 0);
      `CHK("inv done", 1'b1, at > 0)
      r0 = i_mem.reads;
      req(BDF, GPA, 1'b0, 1'b0, 1'b1);
      `CHK("refetch reads", 6, i_mem.reads - r0)
    end
    inv(1'b1, '{INV_DOMAIN, 16'h6, GPA[45:12]}, 0);
    r0 = i_mem.reads;
    req(BDF, GPA, 1'b0, 1'b0, 1'b1);
    `CHK("other domain kept", 2, i_mem.reads - r0)
    $display("test walk_and_invalidate finished");
    for (int n = 0; n < 8; n++) begin
      off = $random(seed);
      a   = n[0] ? {SUP[45:21], off[20:0]} : {GPA[45:12], off[11:0]};
      if (n == 6) a = {GIG[45:30], off[29:0]};
      wr  = off[31];
      req(BDF, a, 1'b0, 1'b0, 1'b1);
      `CHK("random hpa", expect_hpa(a), got.hpa)
      `CHK("random write", wr, got.write)
    end
    wr = 1'b0;
    $display("test random_pages finished");
    repeat (2) begin
      r0 = i_mem.reads;
      req(BDF, BAD, 1'b0, 1'b0, 1'b1);
      `CHK("bad kind", 2, k)
      `CHK("bad code", F_PTE, fl.code)
      `CHK("bad reads", 3, i_mem.reads - r0)
      clr;
    end
    req(16'h0200, GPA, 1'b0, 1'b0, 1'b1);
    `CHK("root fault", F_ROOT, fl.code)
    req(16'h0010, GPA, 1'b0, 1'b0, 1'b1);
    `CHK("held no msi", 0, k)
    `CHK("held code", F_ROOT, o_fault.code)
    clr;
    req(16'h0010, GPA, 1'b0, 1'b0, 1'b1);
    `CHK("gfx unit", F_UNIT, fl.code)
    clr;
    req(BDF, GPA, 1'b0, 1'b1, 1'b1);
    `CHK("tag mode fault", F_MODE, fl.code)
    clr;
    nest = 1'b1;
    req(16'h0010, GPA, 1'b0, 1'b0, 1'b1);
    `CHK("gfx nested", F_MODE, gfx_fault.code)
    clr;
    req(BDF, GPA, 1'b0, 1'b0, 1'b1);
    `CHK("nested walk", expect_hpa(GPA), got.hpa)
    `CHK("gfx other", F_UNIT, gfx_fault.code)
    clr;
    nest = 1'b0;
    $display("test faults finished");
    i_cfg.scalable_en   = 1'b1;
    i_cfg.intr_remap_en = 1'b1;
    req(BDF, GPA, 1'b0, 1'b1, 1'b1);
    `CHK("tag ignored", expect_hpa(GPA), got.hpa)
    req(BDF, 46'h60, 1'b1, 1'b0, 1'b1);
    `CHK("irq vector", 8'h41, got.vector)
    `CHK("irq flag", 1'b1, got.intr)
    `CHK("irq dest", 32'hA5A5_0001, got.dest)
    $display("test scalable_and_interrupt finished");
    stop_test;
  end
endmodule // dma_address_remapping_engine_bench
